// ### hw/ists_limit.v
// Window comparator for one self-test step
`timescale 1ns/100ps
`include "ists_regs.vh"
module ists_limit #(
    parameter W = 16
) (
    input  wire [W-1:0] i_nominal,
    input  wire [W-1:0] i_reading,
    output wire         o_pass
);
    wire [W+4:0] nom20;
    wire [W+4:0] rd20;
    wire [W+4:0] lo;
    wire [W+4:0] hi;
    // Scaled by 20 so five percent is exactly nominal
    assign nom20 = {5'h00, i_nominal} * 21'h14;
    assign rd20  = {5'h00, i_reading} * 21'h14;
    assign lo    = nom20 - {5'h00, i_nominal};
    assign hi    = nom20 + {5'h00, i_nominal};
    // Zero step uses fixed 0..50 mV window
    assign o_pass = (i_nominal == {W{1'b0}}) ? (i_reading <= `ISTS_ZERO_MAX_MV)
                                             : (rd20 >= lo) && (rd20 <= hi);
endmodule

// ### hw/ists_regs.vh
// Constants for the instrument self-test sequencer
`ifndef ISTS_REGS_VH
`define ISTS_REGS_VH
// Command codes on the command port
`define ISTS_CMD_W        3
`define ISTS_CMD_TST      3'h1
`define ISTS_CMD_ERR      3'h2
`define ISTS_CMD_OSC_ON   3'h3
`define ISTS_CMD_OSC_OFF  3'h4
`define ISTS_CMD_OSC_Q    3'h5
`define ISTS_CMD_VER      3'h6
// Test groups in ascending error-number order
`define ISTS_GRP_OUT      3'h0
`define ISTS_GRP_OFS      3'h1
`define ISTS_GRP_CAL      3'h2
`define ISTS_GRP_AMP1     3'h3
`define ISTS_GRP_AMP2     3'h4
`define ISTS_GRP_LAST     3'h4
`define ISTS_ERR_OUT_BASE 16'h0064
`define ISTS_ERR_OFS_BASE 16'h00C8
`define ISTS_ERR_CAL_BASE 16'h0190
`define ISTS_ERR_AMP1_BASE 16'h0258
`define ISTS_ERR_AMP2_BASE 16'h0320
`define ISTS_STEPS_LONG   4'hA
`define ISTS_STEPS_SHORT  4'h5
// Limits in millivolts
`define ISTS_STEP_MV      16'h03E8
`define ISTS_ZERO_MAX_MV  16'h0032
// Self-test failed code -300, two's complement
`define ISTS_ERR_SELFTEST 16'hFED4
`define ISTS_ERR_NONE     16'h0000
// Language version 1990.0 as integer year
`define ISTS_VERSION      16'h07C6
// Settling time in ns and cycles at 25 MHz
`define ISTS_SETTLE_NS    1000
`define ISTS_CLK_NS       40
`define ISTS_SETTLE_CYC   ((`ISTS_SETTLE_NS + `ISTS_CLK_NS - 1) / `ISTS_CLK_NS)
`endif

// ### hw/ists_top.v
// Self-test sequencer with query and calibrator command responses
// Functional notes
// - Self-test query answers 0 when all steps pass, 1 otherwise.
// - Any failure lights amber indicator until error queue read or a passing run ends; read gives -300.
// - Nominal, minimum and maximum of every step are in millivolts.
// - Output DAC stepped 0..10 V by 1 V, errors 100..110 in order.
// - Each reading outside its min or max records that step's error number.
// - Zero step passes 0..50 mV; others within five percent of nominal.
// - Offset DAC stepped six levels to 5 V, errors 200..205.
// - Calibrator DAC stepped 0..10 V by 1 V, errors 400..410.
// - Offset DAC steps, first amplifier measured, errors 600..605.
// - Second stage gain one, offset DAC stepped, errors 800..805.
// - Oscillator on enables 0 dBm 50 MHz calibrator output; off disables.
// - Oscillator query returns 1 when enabled, 0 when disabled.
// - Version query returns compiled command-language version.
`timescale 1ns/100ps
`include "ists_regs.vh"
module ists_top #(
    parameter SETTLE_CYC = `ISTS_SETTLE_CYC
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_cmd_valid,
    input  wire [2:0]  i_cmd,
    input  wire        i_adc_valid,
    input  wire [15:0] i_adc_mv,
    output reg         o_cmd_busy,
    output reg         o_resp_valid,
    output reg  [15:0] o_resp,
    output reg  [2:0]  o_dac_sel,
    output reg  [15:0] o_dac_mv,
    output reg         o_amp2_gain1,
    output reg         o_adc_start,
    output reg         o_err_valid,
    output reg  [15:0] o_err_num,
    output reg         o_trig_led,
    output reg         o_osc_en
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_SET    = 3'h1;
    localparam [2:0] ST_SETTLE = 3'h2;
    localparam [2:0] ST_WAIT   = 3'h3;
    localparam [2:0] ST_CHECK  = 3'h4;
    localparam [2:0] ST_DONE   = 3'h5;

    reg [2:0]  state_q;
    reg [2:0]  grp_q;
    reg [3:0]  step_q;
    reg [15:0] cnt_q;
    reg [15:0] rd_q;
    reg        fail_q;
    reg [15:0] nominal;
    reg [15:0] base;
    reg [3:0]  last;
    wire       pass;

    // Step nominal is step index times one volt
    always @* begin
        nominal = {12'h000, step_q} * `ISTS_STEP_MV;
        base    = `ISTS_ERR_OUT_BASE;
        last    = `ISTS_STEPS_LONG;
        case (grp_q)
            `ISTS_GRP_OUT: begin
                base = `ISTS_ERR_OUT_BASE;
                last = `ISTS_STEPS_LONG;
            end
            `ISTS_GRP_OFS: begin
                base = `ISTS_ERR_OFS_BASE;
                last = `ISTS_STEPS_SHORT;
            end
            `ISTS_GRP_CAL: begin
                base = `ISTS_ERR_CAL_BASE;
                last = `ISTS_STEPS_LONG;
            end
            `ISTS_GRP_AMP1: begin
                base = `ISTS_ERR_AMP1_BASE;
                last = `ISTS_STEPS_SHORT;
            end
            default: begin
                base = `ISTS_ERR_AMP2_BASE;
                last = `ISTS_STEPS_SHORT;
            end
        endcase
    end

    // Limit check on the latched reading
    ists_limit #(
        .W (16)
    ) u_limit (
        .i_nominal (nominal),
        .i_reading (rd_q),
        .o_pass    (pass)
    );

    // Sequencer and command handling
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_q      <= ST_IDLE;
            grp_q        <= 3'h0;
            step_q       <= 4'h0;
            cnt_q        <= 16'h0000;
            rd_q         <= 16'h0000;
            fail_q       <= 1'b0;
            o_cmd_busy   <= 1'b0;
            o_resp_valid <= 1'b0;
            o_resp       <= 16'h0000;
            o_dac_sel    <= 3'h0;
            o_dac_mv     <= 16'h0000;
            o_amp2_gain1 <= 1'b0;
            o_adc_start  <= 1'b0;
            o_err_valid  <= 1'b0;
            o_err_num    <= 16'h0000;
            o_trig_led   <= 1'b0;
            o_osc_en     <= 1'b0;
        end else begin
            o_resp_valid <= 1'b0;
            o_adc_start  <= 1'b0;
            o_err_valid  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (i_cmd_valid) begin
                        o_resp_valid <= 1'b1;
                        o_resp       <= 16'h0000;
                        if (i_cmd == `ISTS_CMD_TST) begin
                            // Fresh run drops old failure records
                            o_resp_valid <= 1'b0;
                            fail_q       <= 1'b0;
                            grp_q        <= `ISTS_GRP_OUT;
                            step_q       <= 4'h0;
                            o_cmd_busy   <= 1'b1;
                            state_q      <= ST_SET;
                        end else if (i_cmd == `ISTS_CMD_ERR) begin
                            // Reading the queue reports and clears the fault
                            o_resp     <= o_trig_led ? `ISTS_ERR_SELFTEST : `ISTS_ERR_NONE;
                            o_trig_led <= 1'b0;
                        end else if (i_cmd == `ISTS_CMD_OSC_ON) begin
                            o_osc_en <= 1'b1;
                        end else if (i_cmd == `ISTS_CMD_OSC_OFF) begin
                            o_osc_en <= 1'b0;
                        end else if (i_cmd == `ISTS_CMD_OSC_Q) begin
                            o_resp <= {15'h0000, o_osc_en};
                        end else if (i_cmd == `ISTS_CMD_VER) begin
                            o_resp <= `ISTS_VERSION;
                        end
                    end
                end
                ST_SET: begin
                    o_dac_sel    <= grp_q;
                    o_dac_mv     <= nominal;
                    o_amp2_gain1 <= (grp_q == `ISTS_GRP_AMP2);
                    cnt_q        <= 16'h0000;
                    state_q      <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    // Sampling too early would judge a moving level
                    if (cnt_q >= SETTLE_CYC[15:0] - 16'h0001) begin
                        o_adc_start <= 1'b1;
                        state_q     <= ST_WAIT;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_WAIT: begin
                    if (i_adc_valid) begin
                        rd_q    <= i_adc_mv;
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (!pass) begin
                        // Error number follows the step level
                        o_err_valid <= 1'b1;
                        o_err_num   <= base + {12'h000, step_q};
                        fail_q      <= 1'b1;
                    end
                    state_q <= ST_SET;
                    if (step_q == last) begin
                        step_q <= 4'h0;
                        if (grp_q == `ISTS_GRP_LAST) begin
                            state_q <= ST_DONE;
                        end else begin
                            grp_q <= grp_q + 3'h1;
                        end
                    end else begin
                        step_q <= step_q + 4'h1;
                    end
                end
                ST_DONE: begin
                    o_resp_valid <= 1'b1;
                    o_resp       <= {15'h0000, fail_q};
                    o_trig_led   <= fail_q;
                    o_amp2_gain1 <= 1'b0;
                    o_dac_mv     <= 16'h0000;
                    o_cmd_busy   <= 1'b0;
                    state_q      <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ### tb/ists_adc_model.sv
// Behavioural system ADC that reads back the DAC under test
`timescale 1ns/100ps
module ists_adc_model (
    input  wire logic        i_clk,
    input  wire logic        i_start,
    input  wire logic        i_bad_en,
    input  wire logic [2:0]  i_sel,
    input  wire logic [2:0]  i_bad_grp,
    input  wire logic [15:0] i_dac,
    input  wire logic [15:0] i_bad_mv,
    output logic             o_valid,
    output logic [15:0]      o_mv
);
    logic [1:0] cnt_q = 2'h0;
    initial begin
        o_valid = 1'b0;
        o_mv = 16'h0000;
    end
    // Idle data toggles so a stale reading is never mistaken for a fresh one
    always @(posedge i_clk) begin
        o_valid <= 1'b0;
        o_mv <= ~o_mv;
        if (i_start) begin
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                o_valid <= 1'b1;
                o_mv <= i_dac + ((i_bad_en && i_sel == i_bad_grp && i_dac == i_bad_mv) ? 16'h0800 : 16'h0000);
            end
        end
    end
endmodule

// ### tb/ists_top_properties.sv
// Port-level assertion checker for the self-test sequencer
`timescale 1ns/100ps
`include "ists_regs.vh"
module ists_top_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_cmd_valid,
    input wire logic [2:0]  i_cmd,
    input wire logic        i_adc_valid,
    input wire logic [15:0] i_adc_mv,
    input wire logic        o_cmd_busy,
    input wire logic        o_resp_valid,
    input wire logic [15:0] o_resp,
    input wire logic [2:0]  o_dac_sel,
    input wire logic [15:0] o_dac_mv,
    input wire logic        o_amp2_gain1,
    input wire logic        o_adc_start,
    input wire logic        o_err_valid,
    input wire logic [15:0] o_err_num,
    input wire logic        o_trig_led,
    input wire logic        o_osc_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire  take = i_cmd_valid && !o_cmd_busy;
    logic seen_q;
    // Any failed step since the test began; the verdict must agree with it
    always @(posedge i_clk) begin
        seen_q <= (i_rst || (take && i_cmd == `ISTS_CMD_TST)) ? 1'b0 : (seen_q | o_err_valid);
    end
    tst_start_a: assert property (take && i_cmd == `ISTS_CMD_TST |=> o_cmd_busy)
        else $error("test did not start");
    osc_on_a: assert property (take && i_cmd == `ISTS_CMD_OSC_ON |=> o_osc_en)
        else $error("oscillator not enabled");
    osc_off_a: assert property (take && i_cmd == `ISTS_CMD_OSC_OFF |=> !o_osc_en)
        else $error("oscillator not disabled");
    osc_query_a: assert property (take && i_cmd == `ISTS_CMD_OSC_Q |=> o_resp_valid && o_resp == {15'h0, o_osc_en})
        else $error("oscillator state wrong");
    version_a: assert property (take && i_cmd == `ISTS_CMD_VER |=> o_resp_valid && o_resp == 16'h07C6)
        else $error("version wrong");
    err_read_a: assert property (take && i_cmd == `ISTS_CMD_ERR && o_trig_led |=> o_resp == 16'hFED4 && !o_trig_led)
        else $error("error read wrong");
    test_result_a: assert property ($fell(o_cmd_busy) |-> o_resp_valid && o_resp == {15'h0, seen_q} && o_trig_led == seen_q)
        else $error("test verdict wrong");
    err_number_a: assert property (o_err_valid |-> o_err_num == o_dac_mv / 16'h03E8 + (o_dac_sel == 3'h0 ? 16'h0064 :
        o_dac_sel == 3'h1 ? 16'h00C8 : o_dac_sel == 3'h2 ? 16'h0190 : o_dac_sel == 3'h3 ? 16'h0258 : 16'h0320))
        else $error("error number wrong");
    settle_a: assert property (o_adc_start |-> $stable(o_dac_mv) && $stable(o_amp2_gain1))
        else $error("sampled before settling");
endmodule
bind ists_top ists_top_chk i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_adc_valid(i_adc_valid), .i_adc_mv(i_adc_mv), .o_cmd_busy(o_cmd_busy), .o_resp_valid(o_resp_valid),
    .o_resp(o_resp), .o_dac_sel(o_dac_sel), .o_dac_mv(o_dac_mv), .o_amp2_gain1(o_amp2_gain1),
    .o_adc_start(o_adc_start), .o_err_valid(o_err_valid), .o_err_num(o_err_num),
    .o_trig_led(o_trig_led), .o_osc_en(o_osc_en));

// ### tb/ists_top_tb.sv
// Self-checking bench for the self-test sequencer
`timescale 1ns/100ps
`include "ists_regs.vh"
module ists_top_tb;
    logic        clk = 0, rst = 1, cmd_v = 0, bad_en = 0, adc_v;
    logic [2:0]  cmd = 0, bad_grp = 0, sel;
    logic [15:0] bad_mv = 0, adc_mv, resp, dac, err_num, last_err;
    logic        busy, resp_v, gain1, start, err_v, led, osc;
    int          failures = 0, num_checks = 0, n_err, n_start;
    always #20 clk = ~clk;
    ists_top #(.SETTLE_CYC(2)) i_dut (.i_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_v), .i_cmd(cmd),
        .i_adc_valid(adc_v), .i_adc_mv(adc_mv), .o_cmd_busy(busy), .o_resp_valid(resp_v),
        .o_resp(resp), .o_dac_sel(sel), .o_dac_mv(dac), .o_amp2_gain1(gain1), .o_adc_start(start),
        .o_err_valid(err_v), .o_err_num(err_num), .o_trig_led(led), .o_osc_en(osc));
    ists_adc_model i_adc (.i_clk(clk), .i_start(start), .i_bad_en(bad_en), .i_sel(sel),
        .i_bad_grp(bad_grp), .i_dac(dac), .i_bad_mv(bad_mv), .o_valid(adc_v), .o_mv(adc_mv));
    // Tally of conversions and failed steps during a test
    always @(posedge clk) begin
        if (start) n_start++;
        if (start) chk({15'h0, gain1}, {15'h0, sel == 3'h4});
        if (err_v) begin
            n_err++;
            last_err = err_num;
        end
    end
    task report_and_stop;
        if (failures == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task send(input logic [2:0] c);
        @(posedge clk);
        cmd_v <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cmd_v <= 1'b0;
        #1;
    endtask
    task query(input logic [2:0] c, input logic [15:0] exp);
        send(c);
        chk({15'h0, resp_v}, 16'h0001);
        chk(resp, exp);
    endtask
    // Full self-test, optionally with one corrupted reading
    task run_test(input logic en, input logic [2:0] g, input logic [15:0] mv, input logic [15:0] e);
        int i;
        bad_en <= en;
        bad_grp <= g;
        bad_mv <= mv;
        n_err = 0;
        n_start = 0;
        send(`ISTS_CMD_TST);
        chk({15'h0, busy}, 16'h0001);
        send(`ISTS_CMD_OSC_ON);
        for (i = 0; i < 2000 && busy; i++) begin
            @(posedge clk);
            #1;
        end
        chk(resp, {15'h0, en});
        chk({15'h0, led}, {15'h0, en});
        chk(n_start[15:0], 16'h0028);
        chk(n_err[15:0], {15'h0, en});
        if (en) chk(last_err, e);
        chk({15'h0, osc}, 16'h0000);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        run_test(1'b0, 3'h0, 16'h0000, 16'h0000);
        run_test(1'b1, 3'h0, 16'h0000, 16'h0064);
        query(`ISTS_CMD_ERR, 16'hFED4);
        chk({15'h0, led}, 16'h0000);
        query(`ISTS_CMD_ERR, 16'h0000);
        run_test(1'b1, 3'h1, 16'h0BB8, 16'h00CB);
        run_test(1'b1, 3'h2, 16'h2710, 16'h019A);
        run_test(1'b1, 3'h3, 16'h0000, 16'h0258);
        run_test(1'b1, 3'h4, 16'h1388, 16'h0325);
        query(`ISTS_CMD_OSC_ON, 16'h0000);
        query(`ISTS_CMD_OSC_Q, 16'h0001);
        query(`ISTS_CMD_OSC_OFF, 16'h0000);
        query(`ISTS_CMD_OSC_Q, 16'h0000);
        query(`ISTS_CMD_VER, 16'h07C6);
        report_and_stop;
    end
endmodule
